// file: common/freq_comp_pkg.sv
package freq_comp_pkg;
  // Register map, byte addresses on the register port
  localparam logic [7:0] ADDR_TEMP = 8'h20;
  localparam logic [7:0] ADDR_CTRL = 8'h30;
  localparam logic [7:0] ADDR_OFFS = 8'h31;
  localparam logic [7:0] ADDR_COEF = 8'h32;
  localparam logic [7:0] ADDR_T0 = 8'h33;
  // Field positions
  localparam int CTRL_PERIOD_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int OFFS_SIGN_BIT = 7;
  localparam int T0_WIDTH = 6;
  // Values after reset
  localparam logic [7:0] TEMP_RST = 8'h55;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [7:0] OFFS_RST = 8'h00;
  localparam logic [7:0] COEF_RST = 8'h00;
  localparam logic [7:0] T0_RST = 8'h15;
  // Time base, counted in reference ticks and seconds
  localparam int REF_HZ = 32768;
  localparam int PRESCALE_W = 15;
  localparam int COMP_PERIOD_S = 32;
  localparam int SEC_CNT_W = 5;
  localparam int THERMO_SHORT_S = 1;
  localparam int THERMO_LONG_S = 16;
  localparam int SPREAD_TICKS = REF_HZ * COMP_PERIOD_S;
  localparam int SPREAD_W = 20;
  // Compensation arithmetic
  localparam logic [9:0] TEMP_ZERO_CODE = 10'h03C;
  localparam logic [9:0] T0_BIAS = 10'h004;
  localparam int COEF_SHIFT = 12;
  localparam int COMP_W = 16;
endpackage

// file: common/comp_if.sv
interface comp_if;
  import freq_comp_pkg::*;
  logic refTick;
  logic load;
  logic addDir;
  logic [COMP_W-1:0] amount;
  logic corrAdd;
  logic corrDrop;
  modport ctrl (output refTick, output load, output addDir, output amount,
    input corrAdd, input corrDrop);
  modport spread (input refTick, input load, input addDir, input amount,
    output corrAdd, output corrDrop);
endinterface

// file: design/corr_pulse_spreader.sv
module corr_pulse_spreader
  import freq_comp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  comp_if.spread bus
);
  logic [SPREAD_W-1:0] acc_reg;
  logic [COMP_W-1:0] amount_reg;
  logic addDir_reg;
  logic [SPREAD_W:0] sum;
  logic carry;

  // Bresenham spreading: n carries out of one period's worth of ticks
  assign sum = {1'b0, acc_reg} + (SPREAD_W+1)'(amount_reg);
  assign carry = bus.refTick && (sum >= (SPREAD_W+1)'(SPREAD_TICKS));
  assign bus.corrAdd = carry && addDir_reg;
  assign bus.corrDrop = carry && !addDir_reg;

  // New period restarts the accumulator so no residue leaks across values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      amount_reg <= '0;
      addDir_reg <= 1'b1;
    end else if (bus.load) begin
      acc_reg <= '0;
      amount_reg <= bus.amount;
      addDir_reg <= bus.addDir;
    end else if (bus.refTick) begin
      acc_reg <= carry ? SPREAD_W'(sum - (SPREAD_W+1)'(SPREAD_TICKS)) : sum[SPREAD_W-1:0];
    end
  end

  chk_one_corr_kind: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus.corrAdd && bus.corrDrop)) else $error("add and drop at once");
  chk_corr_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.corrAdd || bus.corrDrop) |-> bus.refTick) else $error("correction off tick");
endmodule

// file: design/freq_comp_unit.sv
// Notes on behaviour
// - Compensation value is recomputed once every 32-second period.
// - Corrections add or drop single reference pulses, spread over the period.
// - Value depends on offset, turnover temperature, coefficient and latest temperature.
// - Control bit 1 enables thermometer sampling; zero stops it.
// - Control bit 0 picks 1 s or 16 s sampling interval.
// - Each measurement lands in the temperature register at 20h.
// - Temperature code is unsigned, 1 degree per step, code 0 is -60 C.
// - Low-voltage status freezes temperature; compensation keeps using frozen value.
// - Software writes temperature only while thermometer disabled; value then used.
// - Signed offset cancels crystal error at turnover temperature.
// - Coefficient register holds unsigned quadratic drift coefficient 0..255.
// - One correction pulse per period shifts rate by about 0.954 ppm.
// - Turnover register uses bits 5..0; bits 7..6 unused.
module freq_comp_unit
  import freq_comp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic refTick,
  input wire logic [7:0] sensorCode,
  input wire logic lowVoltage1Status,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic secondTick,
  output logic [COMP_W-1:0] compValue
);
  logic rstMeta_reg;
  logic rstSync_n;
  logic [7:0] measuredTemperature_reg;
  logic [7:0] nonvolatileControl_reg;
  logic [7:0] crystalOffsetParam_reg;
  logic [7:0] crystalQuadCoeff_reg;
  logic [7:0] turnoverTempParam_reg;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [SEC_CNT_W-1:0] periodSec_reg;
  logic [3:0] thermoSec_reg;
  logic [7:0] regRdata_reg;
  logic secondTick_reg;
  logic [COMP_W-1:0] compValue_reg;
  logic thermoEnable;
  logic thermoPeriod;
  logic [1:0] prescaleInc;
  logic [PRESCALE_W:0] prescaleSum;
  logic secondEvent;
  logic periodEnd;
  logic sampleNow;
  logic tempWriteOk;
  logic [9:0] tempDiff;
  logic [8:0] tempDiffAbs;
  logic [17:0] tempDiffSq;
  logic [25:0] quadProduct;
  logic [COMP_W-1:0] quadPulses;
  logic [COMP_W-1:0] offsetMag;
  logic [COMP_W-1:0] compNext;

  comp_if cif();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_n <= rstMeta_reg;
    end
  end

  assign thermoEnable = nonvolatileControl_reg[CTRL_ENABLE_BIT];
  assign thermoPeriod = nonvolatileControl_reg[CTRL_PERIOD_BIT];

  // First divider stage: an extra pulse counts double, a dropped one not at all
  assign prescaleInc = cif.corrDrop ? 2'h0 : (cif.corrAdd ? 2'h2 : 2'h1);
  assign prescaleSum = {1'b0, prescale_reg} + (PRESCALE_W+1)'(prescaleInc);
  assign secondEvent = refTick && (prescaleSum >= (PRESCALE_W+1)'(REF_HZ));
  assign periodEnd = secondEvent && (periodSec_reg == SEC_CNT_W'(COMP_PERIOD_S - 1));

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prescale_reg <= '0;
    end else if (refTick) begin
      prescale_reg <= secondEvent ? PRESCALE_W'(prescaleSum - (PRESCALE_W+1)'(REF_HZ))
                                  : prescaleSum[PRESCALE_W-1:0];
    end
  end

  // Compensated seconds drive both the period and the thermometer interval
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      periodSec_reg <= '0;
      thermoSec_reg <= '0;
    end else if (secondEvent) begin
      periodSec_reg <= periodSec_reg + SEC_CNT_W'(1);
      thermoSec_reg <= thermoSec_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      secondTick_reg <= 1'b0;
    end else begin
      secondTick_reg <= secondEvent;
    end
  end

  // Sampling cadence; low supply suspends it and leaves the last code in place
  assign sampleNow = secondEvent && thermoEnable && !lowVoltage1Status
    && (!thermoPeriod || thermoSec_reg == 4'(THERMO_LONG_S - 1));
  // A write while the thermometer runs is dropped, so it cannot race a sample
  assign tempWriteOk = regWrite && (regAddr == ADDR_TEMP) && !thermoEnable;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      measuredTemperature_reg <= TEMP_RST;
    end else if (sampleNow) begin
      measuredTemperature_reg <= sensorCode;
    end else if (tempWriteOk) begin
      measuredTemperature_reg <= regWdata;
    end
  end

  // Parameter and control registers, plain storage
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      nonvolatileControl_reg <= CTRL_RST;
      crystalOffsetParam_reg <= OFFS_RST;
      crystalQuadCoeff_reg <= COEF_RST;
      turnoverTempParam_reg <= T0_RST;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_CTRL: nonvolatileControl_reg <= regWdata;
        ADDR_OFFS: crystalOffsetParam_reg <= regWdata;
        ADDR_COEF: crystalQuadCoeff_reg <= regWdata;
        ADDR_T0: turnoverTempParam_reg <= {2'b00, regWdata[T0_WIDTH-1:0]};
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      regRdata_reg <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_TEMP: regRdata_reg <= measuredTemperature_reg;
        ADDR_CTRL: regRdata_reg <= nonvolatileControl_reg;
        ADDR_OFFS: regRdata_reg <= crystalOffsetParam_reg;
        ADDR_COEF: regRdata_reg <= crystalQuadCoeff_reg;
        ADDR_T0: regRdata_reg <= turnoverTempParam_reg;
        default: regRdata_reg <= 8'h00;
      endcase
    end
  end

  // Temperature minus turnover in degrees: code-60 minus (param+4)
  assign tempDiff = {2'b00, measuredTemperature_reg} - TEMP_ZERO_CODE
    - {2'b00, turnoverTempParam_reg} - T0_BIAS;
  assign tempDiffAbs = tempDiff[9] ? 9'(-tempDiff) : tempDiff[8:0];
  assign tempDiffSq = 18'(tempDiffAbs * tempDiffAbs);
  assign quadProduct = 26'(crystalQuadCoeff_reg * tempDiffSq);
  // Coefficient carries a 4096 scale; a slow crystal gets extra pulses
  assign quadPulses = COMP_W'(quadProduct[25:COEF_SHIFT]);
  assign offsetMag = COMP_W'(crystalOffsetParam_reg[6:0]);
  assign compNext = crystalOffsetParam_reg[OFFS_SIGN_BIT] ? quadPulses - offsetMag
                                                          : quadPulses + offsetMag;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      compValue_reg <= '0;
    end else if (periodEnd) begin
      compValue_reg <= compNext;
    end
  end

  // Spreader gets the value that becomes current with the new period
  assign cif.refTick = refTick;
  assign cif.load = periodEnd;
  assign cif.addDir = !compNext[COMP_W-1];
  assign cif.amount = compNext[COMP_W-1] ? COMP_W'(-compNext) : compNext;

  corr_pulse_spreader spreader (
    .clk(clk),
    .rst_n(rstSync_n),
    .bus(cif)
  );

  assign regRdata = regRdata_reg;
  assign secondTick = secondTick_reg;
  assign compValue = compValue_reg;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstSync_n);

  chk_blocked_temp_write: assert property (
    regWrite && regAddr == ADDR_TEMP && thermoEnable && !sampleNow
    |=> $stable(measuredTemperature_reg)) else $error("write taken while enabled");
  chk_lowv_freezes_temp: assert property (
    lowVoltage1Status && !tempWriteOk |=> $stable(measuredTemperature_reg))
    else $error("temperature moved under low voltage");
  chk_disabled_no_sample: assert property (!thermoEnable |-> !sampleNow)
    else $error("sample while disabled");
  chk_sample_interval: assert property (
    sampleNow |-> secondEvent && (!thermoPeriod || thermoSec_reg == 4'hF))
    else $error("sample off interval");
  chk_sample_stored: assert property (
    sampleNow |=> measuredTemperature_reg == $past(sensorCode))
    else $error("sample not stored");
  chk_comp_updates: assert property (
    periodEnd |=> compValue_reg == $past(compNext)) else $error("value not updated");
  chk_comp_holds: assert property (!periodEnd |=> $stable(compValue_reg))
    else $error("value changed mid period");
  chk_drop_holds_div: assert property (
    cif.corrDrop |=> $stable(prescale_reg)) else $error("dropped pulse counted");
  chk_t0_top_bits: assert property (
    regRead && regAddr == ADDR_T0 |=> regRdata_reg[7:6] == 2'b00)
    else $error("turnover top bits set");

  cov_sample: cover property (sampleNow);
  cov_period_end: cover property (periodEnd && compNext != '0);
  cov_add_pulse: cover property (cif.corrAdd);
  cov_drop_pulse: cover property (cif.corrDrop);
endmodule

// file: dv/freq_comp_unit_tb_top.sv
module freq_comp_unit_tb_top import freq_comp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic refTick = 1'b0;
  logic [7:0] sensorCode = 8'h00;
  logic lowVoltage1Status = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic secondTick;
  logic [COMP_W-1:0] compValue;
  int errors = 0;
  int checked = 0;
  int seed = 14;
  int secGap = -1;
  logic [7:0] expQ[$];
  logic rdLate = 1'b0;
  logic [7:0] s1;
  logic [7:0] v;

  freq_comp_unit i_dut (
    .clk(clk),
    .arst_n(arst_n),
    .refTick(refTick),
    .sensorCode(sensorCode),
    .lowVoltage1Status(lowVoltage1Status),
    .regWrite(regWrite),
    .regRead(regRead),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .secondTick(secondTick),
    .compValue(compValue)
  );

  // Clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end

  // Reference ticks every cycle so one second costs 32768 cycles of run time
  always @(posedge clk) begin
    refTick <= arst_n;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Register read; the expected byte is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
  endtask

  // Bounded wait for the next compensated second
  task automatic waitSec();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (secondTick !== 1'b1 && n < 40000);
    check("secondTick", {15'h0000, secondTick}, 16'h0001);
    if (secondTick !== 1'b1) begin
      conclude();
    end
    @(posedge clk);
  endtask

  // Read data is valid the cycle after the strobe; check at mid-cycle when settled
  always @(posedge clk) begin
    rdLate <= regRead;
  end

  // With no correction pending, every second is one full reference period of ticks
  always @(negedge clk) begin
    if (secondTick === 1'b1) begin
      if (secGap >= 0) begin
        check("second length", 16'(secGap), 16'(REF_HZ - 1));
      end
      secGap <= 0;
    end else if (secGap >= 0) begin
      secGap <= secGap + 1;
    end
  end

  always @(negedge clk) begin
    if (rdLate) begin
      if (expQ.size() == 0) begin
        check("read queue", 16'h0001, 16'h0000);
      end else begin
        check("regRdata", {8'h00, regRdata}, {8'h00, expQ.pop_front()});
      end
    end
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Values after reset, and an unmapped address reading as zero
    rd(ADDR_TEMP, TEMP_RST);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_OFFS, OFFS_RST);
    rd(ADDR_COEF, COEF_RST);
    rd(ADDR_T0, T0_RST);
    rd(8'h34, 8'h00);
    @(negedge clk);
    check("compValue", compValue, 16'h0000);
    $display("Test reset values finished");
    // Parameter registers; turnover keeps only its six low bits
    v = 8'($random(seed));
    wr(ADDR_OFFS, v);
    rd(ADDR_OFFS, v);
    v = 8'($random(seed));
    wr(ADDR_COEF, v);
    rd(ADDR_COEF, v);
    v = 8'($random(seed)) | 8'hC0;
    wr(ADDR_T0, v);
    rd(ADDR_T0, {2'b00, v[5:0]});
    wr(8'h21, v);
    rd(8'h21, 8'h00);
    // Factory parameters go back afterwards; normal software leaves them alone
    wr(ADDR_OFFS, OFFS_RST);
    wr(ADDR_COEF, COEF_RST);
    wr(ADDR_T0, T0_RST);
    $display("Test parameter registers finished");
    // Temperature write is refused while the thermometer runs
    // Forced to differ from the reset code so a taken write would show
    v = (8'($random(seed)) | 8'h01) ^ TEMP_RST;
    wr(ADDR_TEMP, v);
    rd(ADDR_TEMP, TEMP_RST);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_TEMP, v);
    rd(ADDR_TEMP, v);
    wr(ADDR_CTRL, CTRL_RST);
    $display("Test temperature write finished");
    // One-second sampling stores the sensor code
    s1 = v ^ (8'($random(seed)) | 8'h01);
    sensorCode <= s1;
    waitSec();
    rd(ADDR_TEMP, s1);
    // Low voltage freezes the last reading
    lowVoltage1Status <= 1'b1;
    sensorCode <= ~s1;
    waitSec();
    rd(ADDR_TEMP, s1);
    // Sixteen-second interval skips this second
    lowVoltage1Status <= 1'b0;
    wr(ADDR_CTRL, 8'h03);
    waitSec();
    rd(ADDR_TEMP, s1);
    repeat (3) @(negedge clk);
    check("compValue", compValue, 16'h0000);
    $display("Test sampling finished");
    conclude();
  end
endmodule
